// file: hdl/gate_driver_config_status_regs.sv
// configuration and fault status register bank of a three-phase gate driver
`timescale 1ns/1ps
module gate_driver_config_status_regs
    import gd_regs_pkg::*;
#(
    parameter bit HAS_DRV_OV = 1'b1  // driver supply overvoltage detect present
) (
    input  wire logic     core_clk,             // 20 MHz clock
    input  wire logic     rst_n,                // async reset, low
    input  wire logic     brownout,             // internal brown-out reset pulse
    input  wire logic     chip_enable,          // chip enable pin
    input  wire msg_req_s msg_req,              // decoded host message
    input  wire comp_s    comp_raw,             // analog comparator levels
    input  wire logic     pwm_edge,             // gate switching edge
    output logic          pullup_connect,       // link pull-up switch
    output logic [1:0]    power_mode,           // active, standby, sleep
    output logic          neutral_sim_enable,   // neutral simulator on
    output logic          fet_uv_lockout_en,    // lockout enabled
    output logic          fet_short_detect_en,  // short detect enabled
    output logic [1:0]    fet_overcurrent_limit,// limit code
    output logic [7:0]    current_ref_code,     // DAC code
    output logic [2:0]    dead_time_select,     // dead time code
    output logic [1:0]    blanking_time_select, // blanking code
    output logic          dead_time_active,     // dead time window
    output logic          blanking_active,      // blanking window
    output logic          rsp_valid,            // reply byte pair valid
    output logic [7:0]    rsp_byte1,            // reply first byte
    output logic [7:0]    rsp_byte2             // reply second byte
);

    // ==========================================================
    // synchronisers
    comp_s comp_s_sync;
    logic  ce_sync;

    sync2 #(.W($bits(comp_s))) u_comp_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (comp_raw),
        .q        (comp_s_sync)
    );

    sync2 #(.W(1)) u_ce_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (chip_enable),
        .q        (ce_sync)
    );

    // ==========================================================
    // register state
    logic [7:0]  power_mode_protection_config_q, current_reference_dac_code_q, dead_blank_time_config_q;
    logic        bor_q;
    power_mode_e mode_q, mode_d;
    logic [7:0]  stat0_prev_q;

    wire is_cfg_wr  = msg_req.wr;
    wire wr_power_mode_protection_config    = is_cfg_wr && (msg_req.sel == SEL_POWER_MODE_PROTECTION_CONFIG);
    wire wr_current_reference_dac_code    = is_cfg_wr && (msg_req.sel == SEL_CURRENT_REFERENCE_DAC_CODE);
    wire wr_dead_blank_time_config    = is_cfg_wr && (msg_req.sel == SEL_DEAD_BLANK_TIME_CONFIG);
    wire in_standby = (mode_q == PM_STANDBY);

    // keep bit is only written in standby
    wire [7:0] power_mode_protection_config_keep_mask = in_standby ? POWER_MODE_PROTECTION_CONFIG_MASK
                              : (POWER_MODE_PROTECTION_CONFIG_MASK & ~(8'h01 << POWER_MODE_PROTECTION_CONFIG_PULLUP_BIT));
    wire [7:0] power_mode_protection_config_wdata = (msg_req.data & power_mode_protection_config_keep_mask) | (power_mode_protection_config_q & ~power_mode_protection_config_keep_mask);
    wire [7:0] dead_blank_time_config_wdata = msg_req.data & DEAD_BLANK_TIME_CONFIG_MASK;
    wire       dead_blank_time_config_ok    = (msg_req.data & ~DEAD_BLANK_TIME_CONFIG_MASK) == 8'h00;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_mode_protection_config_q <= POWER_MODE_PROTECTION_CONFIG_RST;
            current_reference_dac_code_q <= CURRENT_REFERENCE_DAC_CODE_RST;
            dead_blank_time_config_q <= DEAD_BLANK_TIME_CONFIG_RST;
        end
        else if (brownout)
        begin
            power_mode_protection_config_q <= POWER_MODE_PROTECTION_CONFIG_RST;
            current_reference_dac_code_q <= CURRENT_REFERENCE_DAC_CODE_RST;
            dead_blank_time_config_q <= DEAD_BLANK_TIME_CONFIG_RST;
        end
        else
        begin
            if (wr_power_mode_protection_config)
                power_mode_protection_config_q <= power_mode_protection_config_wdata;
            if (wr_current_reference_dac_code)
                current_reference_dac_code_q <= msg_req.data & CURRENT_REFERENCE_DAC_CODE_MASK;
            if (wr_dead_blank_time_config && dead_blank_time_config_ok)
                dead_blank_time_config_q <= dead_blank_time_config_wdata;
        end
    end

    // warning set on reset, cleared by config message
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bor_q <= 1'b1;
        else if (brownout)
            bor_q <= 1'b1;
        else if (is_cfg_wr)
            bor_q <= 1'b0;
    end

    // ==========================================================
    // power mode
    // sleep or standby on chip enable low
    always_comb
    begin
        mode_d = PM_ACTIVE;
        if (!ce_sync)
            mode_d = power_mode_protection_config_q[POWER_MODE_PROTECTION_CONFIG_SLEEP_BIT] ? PM_SLEEP : PM_STANDBY;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= PM_STANDBY;
        else
            mode_q <= mode_d;
    end

    wire pullup_d = (mode_d == PM_ACTIVE)
                  || ((mode_d == PM_STANDBY) && power_mode_protection_config_q[POWER_MODE_PROTECTION_CONFIG_PULLUP_BIT]);

    // ==========================================================
    // status bytes
    // status0 mirror
    wire [7:0] stat0 = {comp_s_sync.buck_low_fault,
                        comp_s_sync.buck_low_warning,
                        comp_s_sync.buck_input_overcurrent_warning,
                        comp_s_sync.supply_overvoltage_fault,
                        comp_s_sync.driver_supply_overvoltage_fault & HAS_DRV_OV,
                        comp_s_sync.supply_undervoltage_fault,
                        comp_s_sync.overtemp_fault,
                        comp_s_sync.overtemp_warning};

    wire [7:0] driver_fault_status = ({2'b00, comp_s_sync.five_volt_reg_low_fault, bor_q,
                         comp_s_sync.fet_overcurrent_fault & power_mode_protection_config_q[POWER_MODE_PROTECTION_CONFIG_SC_BIT],
                         comp_s_sync.gate_drive_low_fault, 2'b00}) & DRIVER_FAULT_STATUS_MASK;

    wire [7:0] rd_data = (msg_req.sel == SEL_POWER_MODE_PROTECTION_CONFIG)  ? (power_mode_protection_config_q & POWER_MODE_PROTECTION_CONFIG_MASK) :
                         (msg_req.sel == SEL_CURRENT_REFERENCE_DAC_CODE)  ? current_reference_dac_code_q :
                         (msg_req.sel == SEL_DEAD_BLANK_TIME_CONFIG)  ? (dead_blank_time_config_q & DEAD_BLANK_TIME_CONFIG_MASK) :
                         (msg_req.sel == SEL_STAT0) ? stat0 :
                         (msg_req.sel == SEL_DRIVER_FAULT_STATUS) ? driver_fault_status : 8'h00;

    wire stat0_unsol = (stat0 != stat0_prev_q) && !msg_req.wr && !msg_req.rd;

    // ==========================================================
    // replies
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_valid    <= 1'b0;
            rsp_byte1    <= 8'h00;
            rsp_byte2    <= 8'h00;
            stat0_prev_q <= 8'h00;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (wr_dead_blank_time_config)
            begin
                rsp_valid <= 1'b1;
                rsp_byte1 <= dead_blank_time_config_ok ? MSG_DEAD_BLANK_TIME_CONFIG_ACK : MSG_DEAD_BLANK_TIME_CONFIG_NAK;
                rsp_byte2 <= dead_blank_time_config_wdata;
            end
            else if (msg_req.rd)
            begin
                rsp_valid <= 1'b1;
                rsp_byte1 <= {5'h00, msg_req.sel};
                rsp_byte2 <= rd_data;
            end
            else if (stat0_unsol)
            begin
                rsp_valid    <= 1'b1;
                rsp_byte1    <= MSG_STAT0_UNSOL;
                rsp_byte2    <= stat0;
                stat0_prev_q <= stat0;
            end
        end
    end

    // ==========================================================
    // timing windows
    // dead time 2000 ns minus 250 ns steps
    wire [7:0] dt_load = 8'(DT_MAX_CYC - DT_STEP_CYC * int'(dead_blank_time_config_q[DEAD_BLANK_TIME_CONFIG_DT_LSB +: 3]));
    wire [7:0] bl_load = 8'(BL_MAX_CYC >> dead_blank_time_config_q[DEAD_BLANK_TIME_CONFIG_BL_LSB +: 2]);

    sel_timer u_dead (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (pwm_edge),
        .load     (dt_load),
        .busy     (dead_time_active)
    );

    sel_timer u_blank (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (pwm_edge),
        .load     (bl_load),
        .busy     (blanking_active)
    );

    // ==========================================================
    // registered control outputs
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pullup_connect        <= 1'b0;
            power_mode            <= PM_STANDBY;
            neutral_sim_enable    <= 1'b0;
            fet_uv_lockout_en     <= 1'b1;
            fet_short_detect_en   <= 1'b1;
            fet_overcurrent_limit <= 2'b00;
            current_ref_code      <= CURRENT_REFERENCE_DAC_CODE_RST;
            dead_time_select      <= 3'b000;
            blanking_time_select  <= 2'b00;
        end
        else
        begin
            pullup_connect        <= pullup_d;
            power_mode            <= mode_d;
            neutral_sim_enable    <= power_mode_protection_config_q[POWER_MODE_PROTECTION_CONFIG_NSIM_BIT];
            fet_uv_lockout_en     <= ~power_mode_protection_config_q[POWER_MODE_PROTECTION_CONFIG_UVLO_BIT];
            fet_short_detect_en   <= ~power_mode_protection_config_q[POWER_MODE_PROTECTION_CONFIG_SC_BIT];
            fet_overcurrent_limit <= power_mode_protection_config_q[POWER_MODE_PROTECTION_CONFIG_OC_LSB +: 2];
            current_ref_code      <= current_reference_dac_code_q;
            dead_time_select      <= dead_blank_time_config_q[DEAD_BLANK_TIME_CONFIG_DT_LSB +: 3];
            blanking_time_select  <= dead_blank_time_config_q[DEAD_BLANK_TIME_CONFIG_BL_LSB +: 2];
        end
    end

endmodule : gate_driver_config_status_regs

// file: hdl/gd_regs_pkg.sv
// package: register layout, reset values, message codes for the gate driver register bank
package gd_regs_pkg;

    // ==========================================================
    // register selectors on the message port
    localparam logic [2:0] SEL_POWER_MODE_PROTECTION_CONFIG  = 3'h0;
    localparam logic [2:0] SEL_CURRENT_REFERENCE_DAC_CODE  = 3'h1;
    localparam logic [2:0] SEL_DEAD_BLANK_TIME_CONFIG  = 3'h2;
    localparam logic [2:0] SEL_STAT0 = 3'h3;
    localparam logic [2:0] SEL_DRIVER_FAULT_STATUS = 3'h4;

    // ==========================================================
    // implemented bit masks and reset values
    localparam logic [7:0] POWER_MODE_PROTECTION_CONFIG_MASK  = 8'h7F;
    localparam logic [7:0] CURRENT_REFERENCE_DAC_CODE_MASK  = 8'hFF;
    localparam logic [7:0] DEAD_BLANK_TIME_CONFIG_MASK  = 8'h1F;
    localparam logic [7:0] DRIVER_FAULT_STATUS_MASK = 8'h3C;
    localparam logic [7:0] POWER_MODE_PROTECTION_CONFIG_RST   = 8'h00;
    localparam logic [7:0] CURRENT_REFERENCE_DAC_CODE_RST   = 8'h40;
    localparam logic [7:0] DEAD_BLANK_TIME_CONFIG_RST   = 8'h00;

    // ==========================================================
    // field positions
    localparam int POWER_MODE_PROTECTION_CONFIG_PULLUP_BIT = 6;
    localparam int POWER_MODE_PROTECTION_CONFIG_SLEEP_BIT  = 5;
    localparam int POWER_MODE_PROTECTION_CONFIG_NSIM_BIT   = 4;
    localparam int POWER_MODE_PROTECTION_CONFIG_UVLO_BIT   = 3;
    localparam int POWER_MODE_PROTECTION_CONFIG_SC_BIT     = 2;
    localparam int POWER_MODE_PROTECTION_CONFIG_OC_LSB     = 0;
    localparam int DEAD_BLANK_TIME_CONFIG_DT_LSB     = 2;
    localparam int DEAD_BLANK_TIME_CONFIG_BL_LSB     = 0;
    localparam int DRIVER_FAULT_STATUS_5V_BIT    = 5;
    localparam int DRIVER_FAULT_STATUS_BOR_BIT   = 4;
    localparam int DRIVER_FAULT_STATUS_XOC_BIT   = 3;
    localparam int DRIVER_FAULT_STATUS_XUV_BIT   = 2;

    // ==========================================================
    // reply first bytes
    localparam logic [7:0] MSG_STAT0_UNSOL = 8'h85;
    localparam logic [7:0] MSG_DEAD_BLANK_TIME_CONFIG_ACK    = 8'h47;
    localparam logic [7:0] MSG_DEAD_BLANK_TIME_CONFIG_NAK    = 8'h07;

    // ==========================================================
    // timing in ns, cycles derived at 20 MHz
    localparam int CLK_NS      = 50;
    localparam int DT_MAX_NS   = 2000;
    localparam int DT_STEP_NS  = 250;
    localparam int BL_MAX_NS   = 4000;
    localparam int DT_STEP_CYC = (DT_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DT_MAX_CYC  = (DT_MAX_NS + CLK_NS - 1) / CLK_NS;
    localparam int BL_MAX_CYC  = (BL_MAX_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0]
    {
        PM_ACTIVE  = 2'b00,
        PM_STANDBY = 2'b01,
        PM_SLEEP   = 2'b10
    } power_mode_e;

    typedef struct packed
    {
        logic       buck_low_fault;
        logic       buck_low_warning;
        logic       buck_input_overcurrent_warning;
        logic       supply_overvoltage_fault;
        logic       driver_supply_overvoltage_fault;
        logic       supply_undervoltage_fault;
        logic       overtemp_fault;
        logic       overtemp_warning;
        logic       five_volt_reg_low_fault;
        logic       fet_overcurrent_fault;
        logic       gate_drive_low_fault;
    } comp_s;

    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [2:0] sel;
        logic [7:0] data;
    } msg_req_s;

endpackage : gd_regs_pkg

// file: hdl/sel_timer.sv
// down-counter that measures a selected interval in clock cycles
`timescale 1ns/1ps
module sel_timer (
    input  wire logic       core_clk, // clock
    input  wire logic       rst_n,    // async reset, low
    input  wire logic       start,    // load and run
    input  wire logic [7:0] load,     // cycles to count
    output logic            busy      // high while counting
);
    logic [7:0] cnt_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= 8'h00;
        else if (start)
            cnt_q <= load;
        else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            busy <= 1'b0;
        else
            busy <= start | (cnt_q > 8'h01);
    end
endmodule : sel_timer

// file: hdl/sync2.sv
// two flip-flop level synchroniser, parameterised width
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk, // clock
    input  wire logic         rst_n,    // async reset, low
    input  wire logic [W-1:0] d,        // asynchronous input
    output logic      [W-1:0] q         // synchronised level
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : sync2

// file: test/gate_driver_config_status_regs_tb.sv
// self-checking bench of the gate driver register bank
`timescale 1ns/1ps
module gate_driver_config_status_regs_tb
    import gd_regs_pkg::*;
;
    localparam logic [1:0] W = 2'h2;
    localparam logic [1:0] R = 2'h1;
    logic       core_clk, rst_n, brownout, chip_enable, pwm_edge, v;
    logic       pullup_connect, neutral_sim_enable, fet_uv_lockout_en, fet_short_detect_en;
    logic       dead_time_active, blanking_active, rsp_valid;
    logic [1:0] power_mode, fet_overcurrent_limit, blanking_time_select, op;
    logic [2:0] dead_time_select, sel;
    logic [7:0] current_ref_code, rsp_byte1, rsp_byte2, d, b2, e1;
    msg_req_s   cmd, msg_req;
    comp_s      comp_raw;
    int         bad_count = 0, checks_done = 0, cyc = 0, nd, nb, seen;
    logic [20:0] rows [15];

    gd_host host (.core_clk(core_clk), .rst_n(rst_n), .cmd(cmd), .power_mode(power_mode),
        .msg_req(msg_req));
    gate_driver_config_status_regs #(.HAS_DRV_OV(1'b1)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .brownout(brownout), .chip_enable(chip_enable),
        .msg_req(msg_req), .comp_raw(comp_raw), .pwm_edge(pwm_edge),
        .pullup_connect(pullup_connect), .power_mode(power_mode),
        .neutral_sim_enable(neutral_sim_enable), .fet_uv_lockout_en(fet_uv_lockout_en),
        .fet_short_detect_en(fet_short_detect_en),
        .fet_overcurrent_limit(fet_overcurrent_limit), .current_ref_code(current_ref_code),
        .dead_time_select(dead_time_select), .blanking_time_select(blanking_time_select),
        .dead_time_active(dead_time_active), .blanking_active(blanking_active),
        .rsp_valid(rsp_valid), .rsp_byte1(rsp_byte1), .rsp_byte2(rsp_byte2));

    // =====
    // tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic req(input logic [1:0] o, input logic [2:0] s, input logic [7:0] x);
        cmd = {o, s, x};
        @(posedge core_clk);
        #1;
    endtask : req

    task automatic idle(input int n);
        cmd = '0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask : idle

    task automatic rst_chk();
        chk(8'({fet_uv_lockout_en, fet_short_detect_en}), 8'h03);
        chk(8'({neutral_sim_enable, fet_overcurrent_limit}), 8'h00);
        chk(8'({dead_time_select, blanking_time_select}), 8'h00);
        chk(current_ref_code, CURRENT_REFERENCE_DAC_CODE_RST);
    endtask : rst_chk

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    // ========
    // sequence
    initial
    begin
        rst_n = 1'b0;
        brownout = 1'b0;
        chip_enable = 1'b0;
        pwm_edge = 1'b0;
        cmd = '0;
        comp_raw = '0;
        rows = '{{R,3'h0,8'h00,8'h00}, {R,3'h1,8'h00,8'h40}, {R,3'h2,8'h00,8'h00},
            {R,3'h4,8'h00,8'h10}, {W,3'h1,8'hA5,8'h00}, {R,3'h4,8'h00,8'h00},
            {R,3'h1,8'h00,8'hA5}, {W,3'h0,8'h9F,8'h00}, {R,3'h0,8'h00,8'h1F},
            {W,3'h2,8'h1F,8'h1F}, {W,3'h2,8'hE3,8'h00}, {R,3'h2,8'h00,8'h1F},
            {R,3'h5,8'h00,8'h00}, {R,3'h7,8'h00,8'h00}, {W,3'h0,8'h00,8'h00}};
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        idle(4);
        rst_chk();
        foreach (rows[i])
        begin
            {op, sel, d, b2} = rows[i];
            req(op, sel, d);
            v = op[0] || sel == SEL_DEAD_BLANK_TIME_CONFIG;
            e1 = op[0] ? {5'h00, sel} : (d[7:5] == 3'h0 ? MSG_DEAD_BLANK_TIME_CONFIG_ACK : MSG_DEAD_BLANK_TIME_CONFIG_NAK);
            chk(8'(rsp_valid), 8'(v));
            if (v)
                chk(rsp_byte1, e1);
            if (op[0] || (v && d[7:5] == 3'h0))
                chk(rsp_byte2, b2);
        end
        req(W, SEL_POWER_MODE_PROTECTION_CONFIG, 8'h40);
        idle(5);
        chk(8'(pullup_connect), 8'h01);
        chk(8'(power_mode), 8'(PM_STANDBY));
        chip_enable = 1'b1;
        req(W, SEL_POWER_MODE_PROTECTION_CONFIG, 8'h60);
        idle(5);
        chk(8'(power_mode), 8'(PM_ACTIVE));
        chip_enable = 1'b0;
        idle(5);
        chk(8'(power_mode), 8'(PM_SLEEP));
        chk(8'(pullup_connect), 8'h00);
        chip_enable = 1'b1;
        req(W, SEL_POWER_MODE_PROTECTION_CONFIG, 8'h00);
        idle(5);
        chip_enable = 1'b0;
        idle(5);
        chk(8'(pullup_connect), 8'h01);
        req(W, SEL_POWER_MODE_PROTECTION_CONFIG, 8'h00);
        idle(5);
        chk(8'(pullup_connect), 8'h00);
        // short flag is only reported with the short control bit set
        req(W, SEL_POWER_MODE_PROTECTION_CONFIG, 8'h04);
        idle(2);
        for (int i = 0; i < 11; i++)
        begin
            comp_raw = comp_s'(11'h001 << i);
            seen = 0;
            repeat (6)
            begin
                @(posedge core_clk);
                #1;
                if (rsp_valid === 1'b1 && rsp_byte1 === MSG_STAT0_UNSOL)
                    seen++;
            end
            chk(8'(seen), 8'(i >= 3));
            req(R, SEL_STAT0, 8'h00);
            chk(rsp_byte2, comp_raw[10:3]);
            req(R, SEL_DRIVER_FAULT_STATUS, 8'h00);
            chk(rsp_byte2, {2'h0, comp_raw[2], 1'b0, comp_raw[1:0], 2'h0});
            comp_raw = '0;
            idle(6);
        end
        for (int c = 0; c < 8; c++)
        begin
            req(W, SEL_DEAD_BLANK_TIME_CONFIG, {3'h0, c[2:0], c[1:0]});
            pwm_edge = 1'b1;
            idle(1);
            pwm_edge = 1'b0;
            nd = 0;
            nb = 0;
            repeat (100)
            begin
                nd += dead_time_active;
                nb += blanking_active;
                @(posedge core_clk);
                #1;
            end
            chk(8'(nd), 8'(DT_MAX_CYC - c * DT_STEP_CYC));
            chk(8'(nb), 8'(BL_MAX_CYC >> c[1:0]));
        end
        req(W, SEL_POWER_MODE_PROTECTION_CONFIG, 8'h1F);
        brownout = 1'b1;
        idle(1);
        brownout = 1'b0;
        idle(3);
        rst_chk();
        req(R, SEL_POWER_MODE_PROTECTION_CONFIG, 8'h00);
        chk(rsp_byte2, POWER_MODE_PROTECTION_CONFIG_RST);
        req(R, SEL_DRIVER_FAULT_STATUS, 8'h00);
        chk(rsp_byte2, 8'h10);
        idle(2);
        print_verdict();
    end
endmodule : gate_driver_config_status_regs_tb

// file: test/gd_host.sv
// host model: hands bench requests to the device message port
`timescale 1ns/1ps
module gd_host
    import gd_regs_pkg::*;
(
    input  wire logic       core_clk,   // clock
    input  wire logic       rst_n,      // reset, low
    input  wire msg_req_s   cmd,        // bench request
    input  wire logic [1:0] power_mode, // device mode
    output msg_req_s        msg_req     // to device
);
    logic keep_q;
    wire  w0  = cmd.wr && cmd.sel == SEL_POWER_MODE_PROTECTION_CONFIG;
    wire  sby = power_mode == PM_STANDBY;
    always_comb
    begin
        msg_req = cmd;
        if (w0 && !sby)
            msg_req.data[POWER_MODE_PROTECTION_CONFIG_PULLUP_BIT] = keep_q;
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            keep_q <= 1'b0;
        else if (w0 && sby)
            keep_q <= cmd.data[POWER_MODE_PROTECTION_CONFIG_PULLUP_BIT];
    end
endmodule : gd_host

// file: test/gd_regs_asserts.sv
// port checker of the gate driver register bank
`timescale 1ns/1ps
module gd_regs_chk
    import gd_regs_pkg::*;
(
    input wire logic       core_clk,              // clock
    input wire logic       rst_n,                 // reset
    input wire msg_req_s   msg_req,               // message
    input wire logic [1:0] power_mode,            // mode
    input wire logic       pullup_connect,        // pull-up
    input wire logic       neutral_sim_enable,    // sim on
    input wire logic       fet_uv_lockout_en,     // lockout
    input wire logic       fet_short_detect_en,   // short det
    input wire logic [1:0] fet_overcurrent_limit, // limit
    input wire logic [7:0] current_ref_code,      // dac
    input wire logic [2:0] dead_time_select,      // dead
    input wire logic [1:0] blanking_time_select,  // blank
    input wire logic       rsp_valid,             // reply
    input wire logic [7:0] rsp_byte1,             // code
    input wire logic [7:0] rsp_byte2              // data
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    wire w0   = msg_req.wr && msg_req.sel == SEL_POWER_MODE_PROTECTION_CONFIG;
    wire w1   = msg_req.wr && msg_req.sel == SEL_CURRENT_REFERENCE_DAC_CODE;
    wire w2   = msg_req.wr && msg_req.sel == SEL_DEAD_BLANK_TIME_CONFIG;
    wire ok2  = w2 && msg_req.data[7:5] == 3'h0;
    wire rd2  = msg_req.rd && !msg_req.wr && msg_req.sel == SEL_DEAD_BLANK_TIME_CONFIG;
    wire idle = !msg_req.wr && !msg_req.rd;
    // ==========
    // assertions
    dead_blank_time_config_ack_a: assert property (ok2 |=> rsp_valid && rsp_byte1 == MSG_DEAD_BLANK_TIME_CONFIG_ACK)
        else $error("dead_blank_time_config write not acknowledged");
    // config outputs follow the register one cycle later, so checks land two edges on
    dead_blank_time_config_nak_a: assert property (w2 && !ok2 |=> rsp_byte1 == MSG_DEAD_BLANK_TIME_CONFIG_NAK
        ##1 ($stable(dead_time_select) && $stable(blanking_time_select)))
        else $error("refused dead_blank_time_config write changed state");
    time_fields_a: assert property (ok2 |-> ##2 dead_time_select == $past(msg_req.data[4:2], 2)
        && blanking_time_select == $past(msg_req.data[1:0], 2))
        else $error("time fields not loaded");
    dac_load_a: assert property (w1 |-> ##2 current_ref_code == $past(msg_req.data, 2))
        else $error("dac code not loaded");
    inv_sense_a: assert property (w0 |-> ##2 fet_uv_lockout_en != $past(msg_req.data[3], 2)
        && fet_short_detect_en != $past(msg_req.data[2], 2))
        else $error("inverted enables wrong");
    power_mode_protection_config_fields_a: assert property (w0 |-> ##2 neutral_sim_enable == $past(msg_req.data[4], 2)
        && fet_overcurrent_limit == $past(msg_req.data[1:0], 2))
        else $error("power_mode_protection_config fields not loaded");
    sleep_pullup_a: assert property (power_mode == PM_SLEEP [*2] |-> !pullup_connect)
        else $error("pull-up kept in sleep");
    dead_blank_time_config_read_a: assert property (rd2 |=> rsp_valid && rsp_byte2 == {3'h0,
        $past(dead_time_select), $past(blanking_time_select)})
        else $error("dead_blank_time_config read wrong");
    quiet_a: assert property (idle |=> !rsp_valid || rsp_byte1 == MSG_STAT0_UNSOL)
        else $error("reply without message");
    cover property (w2 && !ok2);
    cover property (power_mode == PM_SLEEP);
    cover property (rsp_valid && rsp_byte1 == MSG_STAT0_UNSOL);
endmodule : gd_regs_chk

bind gate_driver_config_status_regs gd_regs_chk u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .msg_req(msg_req), .power_mode(power_mode),
    .pullup_connect(pullup_connect), .neutral_sim_enable(neutral_sim_enable),
    .fet_uv_lockout_en(fet_uv_lockout_en), .fet_short_detect_en(fet_short_detect_en),
    .fet_overcurrent_limit(fet_overcurrent_limit), .current_ref_code(current_ref_code),
    .dead_time_select(dead_time_select), .blanking_time_select(blanking_time_select),
    .rsp_valid(rsp_valid), .rsp_byte1(rsp_byte1), .rsp_byte2(rsp_byte2)
);
